// ---- rtl/pattern_fill_blit.sv ----
// Pattern fill blit engine with AHB-Lite register slave and display memory master
`timescale 1ns/1ps
`default_nettype none
module pattern_fill_blit (
  input  wire logic        hclk,       // 100 MHz clock
  input  wire logic        hresetn,    // Asynchronous reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic [2:0]  hsize,      // Transfer size
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready
  output logic             hreadyout,  // Low in reset, ready from the first clock after, zero wait
  output logic      [31:0] hrdata,     // Read data
  output logic             hresp,      // Always OKAY
  output logic             mem_req,    // Display memory request, held to ack
  output logic             mem_we,     // Write when high
  output logic      [23:0] mem_addr,   // Byte address, word aligned
  output logic      [1:0]  mem_be,     // Byte enables for writes
  output logic      [15:0] mem_wdata,  // Write word
  input  wire logic        mem_ack,    // One-cycle completion pulse
  input  wire logic [15:0] mem_rdata,  // Read word, valid with ack
  output logic             busy        // Blit running
);

  // Configuration bytes, indexed from the control register
  logic [7:0]  cfg_reg [0:pattern_fill_pkg::REG_COUNT-1];
  logic        start_pend_reg;        // Start written, engine not yet begun
  logic        wr_pend_reg;           // Data phase of a write is due
  logic [4:0]  wr_slot_reg;           // Register slot of that write
  pattern_fill_pkg::engine_state_t state_reg;  // Engine state
  logic        active_reg;            // Engine running

  // Working copies and counters
  logic [23:0] pat_base_reg;          // Aligned pattern base
  logic [2:0]  col0_reg;              // Starting pattern column
  logic [2:0]  row0_reg;              // Starting pattern row
  logic [2:0]  col_reg;               // Current pattern column
  logic [2:0]  row_reg;               // Current pattern row
  logic [15:0] x_reg;                 // Pixel within line
  logic [15:0] y_reg;                 // Line within blit
  logic [23:0] line_addr_reg;         // First pixel of current line
  logic [23:0] pix_addr_reg;          // Current destination pixel
  logic [6:0]  load_idx_reg;          // Pattern pixel being fetched
  logic [15:0] dst_pix_reg;           // Destination pixel read back
  logic        ram_we_reg;            // Pattern store write strobe
  logic [15:0] ram_wdata_reg;         // Pixel for the pattern store
  logic [5:0]  ram_waddr_reg;         // Its index

  // Decoded configuration
  logic        mode16;
  logic [23:0] src_addr;
  logic [23:0] dst_addr;
  logic [15:0] width_m1;
  logic [15:0] height_m1;
  logic [15:0] stride_words;
  logic [15:0] trans_color;
  logic [23:0] line_step;
  logic [15:0] ram_rdata;
  logic [15:0] rop_result;
  logic        pix_transparent;
  logic        rop_needs_dst;
  logic [15:0] pat_pixel;
  logic [7:0]  fmt_byte;              // Color format register
  logic [7:0]  ctl_byte;              // Control register
  logic [7:0]  rop_byte;              // Raster code register

  // Slot of a register index, or all ones when unmapped
  function automatic logic [4:0] slot_of(input logic [9:0] idx);
    logic [9:0] rel;
    rel = idx - pattern_fill_pkg::IDX_CONTROL;
    if (idx < pattern_fill_pkg::IDX_CONTROL || rel >= 10'(pattern_fill_pkg::REG_COUNT)) begin
      slot_of = 5'h1F;
    end else if (idx == 10'h107 || idx == 10'h10B || idx == 10'h10E || idx == 10'h10F) begin
      slot_of = 5'h1F;                // Holes in the map
    end else begin
      slot_of = rel[4:0];
    end
  endfunction

  // Address of a pixel offset from a base, one or two bytes per pixel
  function automatic logic [23:0] pix_offset(input logic [23:0] base,
                                             input logic [15:0] n,
                                             input logic        wide);
    pix_offset = base + (wide ? {7'h00, n, 1'b0} : {8'h00, n});
  endfunction

  // Pick one byte of a word read at 8 bpp, the whole word at 15/16 bpp
  function automatic logic [15:0] pick_pixel(input logic [15:0] word,
                                             input logic        lane,
                                             input logic        wide);
    if (wide) begin
      pick_pixel = word;
    end else begin
      pick_pixel = {8'h00, lane ? word[15:8] : word[7:0]};
    end
  endfunction

  function automatic logic [7:0] cfg(input logic [9:0] idx);
    cfg = cfg_reg[slot_of(idx)];
  endfunction

  // Decoded configuration; a process, so the register reads inside cfg() wake it
  // Rectangular blits step by the stride in words (twice that in bytes); linear ones pack lines end to end
  always_comb begin
    fmt_byte     = cfg(pattern_fill_pkg::IDX_FORMAT);
    ctl_byte     = cfg(pattern_fill_pkg::IDX_CONTROL);
    rop_byte     = cfg(pattern_fill_pkg::IDX_ROP_CODE);
    mode16       = fmt_byte[pattern_fill_pkg::FMT_16BPP_BIT];
    src_addr     = {cfg(pattern_fill_pkg::IDX_SRC_HIGH), cfg(pattern_fill_pkg::IDX_SRC_MID),
                    cfg(pattern_fill_pkg::IDX_SRC_LOW)};
    dst_addr     = {cfg(pattern_fill_pkg::IDX_DST_HIGH), cfg(pattern_fill_pkg::IDX_DST_MID),
                    cfg(pattern_fill_pkg::IDX_DST_LOW)};
    width_m1     = {cfg(pattern_fill_pkg::IDX_WIDTH_HI), cfg(pattern_fill_pkg::IDX_WIDTH_LOW)};
    height_m1    = {cfg(pattern_fill_pkg::IDX_HEIGHT_HI), cfg(pattern_fill_pkg::IDX_HEIGHT_LOW)};
    stride_words = {cfg(pattern_fill_pkg::IDX_STRIDE_HI), cfg(pattern_fill_pkg::IDX_STRIDE_LOW)};
    trans_color  = {cfg(pattern_fill_pkg::IDX_TRANS_HI), cfg(pattern_fill_pkg::IDX_TRANS_LOW)};
    line_step    = ctl_byte[pattern_fill_pkg::CTRL_DST_LIN_BIT]
                 ? pix_offset(24'h000000, 16'(width_m1 + 16'h0001), mode16)
                 : {7'h00, stride_words, 1'b0};
  end

  // Pattern pixel; stale outside the pixel states, never used there
  assign pat_pixel = ram_rdata;

  pattern_ram u_pattern_ram (
    .clk   (hclk),
    .we    (ram_we_reg),
    .waddr (ram_waddr_reg),
    .wdata (ram_wdata_reg),
    .raddr ({row_reg, col_reg}),
    .rdata (ram_rdata)
  );

  raster_op_unit u_raster_op_unit (
    .rop_code    (rop_byte[3:0]),
    .pat_pixel   (pat_pixel),
    .dst_pixel   (dst_pix_reg),
    .trans_color (trans_color),
    .mode16      (mode16),
    .result      (rop_result),
    .transparent (pix_transparent),
    .needs_dst   (rop_needs_dst)
  );

  // Bus address phase: aligned word accesses in the low 4 KB; only mapped slots take writes, unmapped reads return zero
  logic       addr_take;
  logic [4:0] addr_slot;
  assign addr_take = hsel && hready && (htrans == pattern_fill_pkg::HTRANS_NONSEQ)
                     && (hsize == pattern_fill_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0)
                     && (haddr[31:12] == 20'h00000);
  assign addr_slot = slot_of(haddr[11:2]);

  // Bus response is fixed from the first clock after reset: never stalls, never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Latch the write target for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_slot_reg <= 5'h1F;
    end else begin
      wr_pend_reg <= addr_take && hwrite && (addr_slot != 5'h1F);
      wr_slot_reg <= addr_slot;
    end
  end

  // Read data registered during the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      if (addr_slot == 5'h1F) begin
        hrdata <= 32'h00000000;       // Unmapped reads as zero
      end else if (addr_slot == 5'h00) begin
        hrdata <= {24'h000000, active_reg, 5'h00,
                   cfg_reg[0][1:0]};
      end else begin
        hrdata <= {24'h000000, cfg_reg[addr_slot]};
      end
    end
  end

  // Configuration bytes; control keeps only its select bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < pattern_fill_pkg::REG_COUNT; i++) begin
        cfg_reg[i] <= pattern_fill_pkg::REG_RESET;
      end
    end else if (wr_pend_reg) begin
      if (wr_slot_reg == 5'h00) begin
        cfg_reg[0] <= hwdata[7:0] & pattern_fill_pkg::CTRL_WRITE_MASK;
      end else begin
        cfg_reg[wr_slot_reg] <= hwdata[7:0];
      end
    end
  end

  // Start request; a start written while running is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_pend_reg <= 1'b0;
    end else if (wr_pend_reg && wr_slot_reg == 5'h00 && hwdata[pattern_fill_pkg::CTRL_START_BIT]
                 && !active_reg) begin
      start_pend_reg <= 1'b1;
    end else if (state_reg == pattern_fill_pkg::ST_IDLE) begin
      start_pend_reg <= 1'b0;
    end
  end

  // Engine sequencer and datapath
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= pattern_fill_pkg::ST_IDLE;
      active_reg    <= 1'b0;
      busy          <= 1'b0;
      mem_req       <= 1'b0;
      mem_we        <= 1'b0;
      mem_addr      <= 24'h000000;
      mem_be        <= 2'h0;
      mem_wdata     <= 16'h0000;
      pat_base_reg  <= 24'h000000;
      col0_reg      <= 3'h0;
      row0_reg      <= 3'h0;
      col_reg       <= 3'h0;
      row_reg       <= 3'h0;
      x_reg         <= 16'h0000;
      y_reg         <= 16'h0000;
      line_addr_reg <= 24'h000000;
      pix_addr_reg  <= 24'h000000;
      load_idx_reg  <= 7'h00;
      dst_pix_reg   <= 16'h0000;
      ram_we_reg    <= 1'b0;
      ram_wdata_reg <= 16'h0000;
      ram_waddr_reg <= 6'h00;
    end else begin
      ram_we_reg <= 1'b0;
      case (state_reg)
        pattern_fill_pkg::ST_IDLE: begin
          // Only the two pattern operations run; other codes leave the engine idle
          if (start_pend_reg && (cfg(pattern_fill_pkg::IDX_OPERATION) == pattern_fill_pkg::OP_PATTERN_ROP
              || cfg(pattern_fill_pkg::IDX_OPERATION) == pattern_fill_pkg::OP_PATTERN_TRN)) begin
            active_reg   <= 1'b1;
            busy         <= 1'b1;
            // Base from the aligned high bits, phase from the low ones
            pat_base_reg <= src_addr & ~(mode16 ? pattern_fill_pkg::PAT_MASK_16
                                                : pattern_fill_pkg::PAT_MASK_8);
            col0_reg     <= mode16 ? src_addr[3:1] : src_addr[2:0];
            row0_reg     <= mode16 ? src_addr[6:4] : src_addr[5:3];
            load_idx_reg <= 7'h00;
            mem_req      <= 1'b1;
            mem_we       <= 1'b0;
            // First fetch is the aligned pattern base itself
            mem_addr     <= src_addr & ~(mode16 ? pattern_fill_pkg::PAT_MASK_16
                                                : pattern_fill_pkg::PAT_MASK_8);
            state_reg    <= pattern_fill_pkg::ST_LOAD_WAIT;
          end
        end
        pattern_fill_pkg::ST_LOAD_WAIT: begin
          // Fetch all 64 pattern pixels into the local store, one per read
          if (mem_ack) begin
            ram_we_reg    <= 1'b1;
            ram_waddr_reg <= load_idx_reg[5:0];
            ram_wdata_reg <= pick_pixel(mem_rdata, load_idx_reg[0], mode16);
            if (load_idx_reg == pattern_fill_pkg::PAT_LAST) begin
              mem_req       <= 1'b0;
              col_reg       <= col0_reg;
              row_reg       <= row0_reg;
              x_reg         <= 16'h0000;
              y_reg         <= 16'h0000;
              line_addr_reg <= dst_addr;
              pix_addr_reg  <= dst_addr;
              state_reg     <= pattern_fill_pkg::ST_PIX_SETUP;
            end else begin
              load_idx_reg <= load_idx_reg + 7'h01;
              mem_addr     <= pix_offset(pat_base_reg, {9'h000, 7'(load_idx_reg + 7'h01)},
                                         mode16) & 24'hFFFFFE;
            end
          end
        end
        pattern_fill_pkg::ST_PIX_SETUP: begin
          // Pattern store read is in flight; wait out the last load write first
          if (!ram_we_reg) begin
            state_reg <= pattern_fill_pkg::ST_PIX_DEC;
          end
        end
        pattern_fill_pkg::ST_PIX_DEC: begin
          mem_addr  <= {pix_addr_reg[23:1], 1'b0};
          mem_be    <= mode16 ? 2'h3 : (pix_addr_reg[0] ? 2'h2 : 2'h1);
          if (cfg(pattern_fill_pkg::IDX_OPERATION) == pattern_fill_pkg::OP_PATTERN_TRN) begin
            if (pix_transparent) begin
              state_reg <= pattern_fill_pkg::ST_ADVANCE;
            end else begin
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_wdata <= mode16 ? pat_pixel : {pat_pixel[7:0], pat_pixel[7:0]};
              state_reg <= pattern_fill_pkg::ST_DST_WR;
            end
          end else if (rop_needs_dst) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            state_reg <= pattern_fill_pkg::ST_DST_RD;
          end else begin
            // Code ignores the destination, so no read is spent on it
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_wdata <= mode16 ? rop_result : {rop_result[7:0], rop_result[7:0]};
            state_reg <= pattern_fill_pkg::ST_DST_WR;
          end
        end
        pattern_fill_pkg::ST_DST_RD: begin
          if (mem_ack) begin
            mem_req     <= 1'b0;
            dst_pix_reg <= pick_pixel(mem_rdata, pix_addr_reg[0], mode16);
            state_reg   <= pattern_fill_pkg::ST_DST_MERGE;
          end
        end
        pattern_fill_pkg::ST_DST_MERGE: begin
          // Combined pixel is ready once the destination is registered
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_wdata <= mode16 ? rop_result : {rop_result[7:0], rop_result[7:0]};
          state_reg <= pattern_fill_pkg::ST_DST_WR;
        end
        pattern_fill_pkg::ST_DST_WR: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            state_reg <= pattern_fill_pkg::ST_ADVANCE;
          end
        end
        pattern_fill_pkg::ST_ADVANCE: begin
          if (x_reg == width_m1) begin
            if (y_reg == height_m1) begin
              active_reg <= 1'b0;
              busy       <= 1'b0;
              state_reg  <= pattern_fill_pkg::ST_IDLE;
            end else begin
              x_reg         <= 16'h0000;
              col_reg       <= col0_reg;
              y_reg         <= y_reg + 16'h0001;
              row_reg       <= row_reg + 3'h1;
              line_addr_reg <= line_addr_reg + line_step;
              pix_addr_reg  <= line_addr_reg + line_step;
              state_reg     <= pattern_fill_pkg::ST_PIX_SETUP;
            end
          end else begin
            x_reg        <= x_reg + 16'h0001;
            col_reg      <= col_reg + 3'h1;
            pix_addr_reg <= pix_offset(pix_addr_reg, 16'h0001, mode16);
            state_reg    <= pattern_fill_pkg::ST_PIX_SETUP;
          end
        end
        default: begin
          state_reg  <= pattern_fill_pkg::ST_IDLE;
          active_reg <= 1'b0;
          busy       <= 1'b0;
          mem_req    <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- common/pattern_fill_pkg.sv ----
// Shared constants, register indices and state encoding for the pattern fill engine
package pattern_fill_pkg;

  // Register indices; the AHB byte address of each is four times its index
  localparam logic [9:0] IDX_CONTROL    = 10'h100;
  localparam logic [9:0] IDX_FORMAT     = 10'h101;
  localparam logic [9:0] IDX_ROP_CODE   = 10'h102;
  localparam logic [9:0] IDX_OPERATION  = 10'h103;
  localparam logic [9:0] IDX_SRC_LOW    = 10'h104;
  localparam logic [9:0] IDX_SRC_MID    = 10'h105;
  localparam logic [9:0] IDX_SRC_HIGH   = 10'h106;
  localparam logic [9:0] IDX_DST_LOW    = 10'h108;
  localparam logic [9:0] IDX_DST_MID    = 10'h109;
  localparam logic [9:0] IDX_DST_HIGH   = 10'h10A;
  localparam logic [9:0] IDX_STRIDE_LOW = 10'h10C;
  localparam logic [9:0] IDX_STRIDE_HI  = 10'h10D;
  localparam logic [9:0] IDX_WIDTH_LOW  = 10'h110;
  localparam logic [9:0] IDX_WIDTH_HI   = 10'h111;
  localparam logic [9:0] IDX_HEIGHT_LOW = 10'h112;
  localparam logic [9:0] IDX_HEIGHT_HI  = 10'h113;
  localparam logic [9:0] IDX_TRANS_LOW  = 10'h114;
  localparam logic [9:0] IDX_TRANS_HI   = 10'h115;
  localparam int         REG_COUNT      = 22;

  // Control register fields
  localparam int         CTRL_START_BIT    = 7;
  localparam int         CTRL_DST_LIN_BIT  = 0;
  localparam int         CTRL_SRC_LIN_BIT  = 1;
  localparam logic [7:0] CTRL_WRITE_MASK   = 8'h03;

  // Color format field and operation codes
  localparam int         FMT_16BPP_BIT  = 0;
  localparam logic [7:0] OP_PATTERN_ROP = 8'h06;
  localparam logic [7:0] OP_PATTERN_TRN = 8'h07;
  localparam logic [7:0] ROP_COPY       = 8'h0C;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // Pattern geometry
  localparam int         PAT_SIDE      = 8;
  localparam int         PAT_PIXELS    = 64;
  localparam logic [6:0] PAT_LAST      = 7'h3F;
  localparam logic [23:0] PAT_MASK_8   = 24'h00003F;
  localparam logic [23:0] PAT_MASK_16  = 24'h00007F;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Engine states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_LOAD_WAIT = 8'h02,
    ST_PIX_SETUP = 8'h04,
    ST_PIX_DEC   = 8'h08,
    ST_DST_RD    = 8'h10,
    ST_DST_MERGE = 8'h20,
    ST_DST_WR    = 8'h40,
    ST_ADVANCE   = 8'h80
  } engine_state_t;

endpackage

// ---- rtl/pattern_ram.sv ----
// Eight by eight pattern store with registered read data
`timescale 1ns/1ps
`default_nettype none
module pattern_ram (
  input  wire logic        clk,     // Engine clock
  input  wire logic        we,      // Write strobe
  input  wire logic [5:0]  waddr,   // Write pixel index
  input  wire logic [15:0] wdata,   // Pixel to store
  input  wire logic [5:0]  raddr,   // Read pixel index, row*8+column
  output logic      [15:0] rdata    // Pixel, one cycle after raddr
);

  logic [15:0] mem [0:63];          // One pixel per entry

  // Write port; no reset, contents are reloaded at every blit
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the pixel path off the address decode
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// ---- rtl/raster_op_unit.sv ----
// Per-pixel raster operation and transparency compare
`timescale 1ns/1ps
`default_nettype none
module raster_op_unit (
  input  wire logic [3:0]  rop_code,    // Truth table over pattern and destination
  input  wire logic [15:0] pat_pixel,   // Pattern pixel
  input  wire logic [15:0] dst_pixel,   // Destination pixel read back
  input  wire logic [15:0] trans_color, // Transparent color
  input  wire logic        mode16,      // High for 15/16 bpp
  output logic      [15:0] result,      // Combined pixel
  output logic             transparent, // Pattern pixel matches transparent color
  output logic             needs_dst    // Result depends on destination
);

  // Each result bit is the code bit picked by {pattern bit, destination bit}
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      result[i] = rop_code[{pat_pixel[i], dst_pixel[i]}];
    end
  end

  // Lookup index compare at 8 bpp, direct color compare at 15/16 bpp
  assign transparent = mode16 ? (pat_pixel == trans_color)
                              : (pat_pixel[7:0] == trans_color[7:0]);

  // Destination read is skipped when the code ignores it
  assign needs_dst = (rop_code[1] != rop_code[0]) || (rop_code[3] != rop_code[2]);

endmodule
`default_nettype wire

// ---- sim/display_mem_model.sv ----
// Behavioural display memory that answers the engine's request link
`timescale 1ns/1ps
`default_nettype none
module display_mem_model (
  input  wire logic        clk,   // Engine clock
  input  wire logic        slow,  // Answer one cycle later
  input  wire logic        req,   // Request level
  input  wire logic        we,    // Write when high
  input  wire logic [23:0] addr,  // Byte address
  input  wire logic [1:0]  be,    // Byte lanes
  input  wire logic [15:0] wdata, // Write word
  output logic             ack,   // Completion pulse
  output logic      [15:0] rdata  // Read word, valid beside ack only
);
  logic [7:0] m [0:256];  // Byte store, low addresses only
  logic       wait_reg;   // Slow mode extra cycle
  initial rdata = 16'h5A5A;
  // One answer per request; read data scrambles outside ack
  always @(posedge clk) begin
    wait_reg <= slow & ~wait_reg & req & ~ack;
    ack <= req & ~ack & (~slow | wait_reg);
    rdata <= ~rdata;
    if (req && !ack && (!slow || wait_reg)) begin
      rdata <= {m[addr[7:0] + 9'h1], m[addr[7:0]]};
      if (we && be[0]) m[addr[7:0]] <= wdata[7:0];
      if (we && be[1]) m[addr[7:0] + 9'h1] <= wdata[15:8];
    end
  end
endmodule
`default_nettype wire

// ---- sim/pattern_fill_blit_assertions.sv ----
// Concurrent checks on the engine's bus slave and memory link
`timescale 1ns/1ps
`default_nettype none
module pattern_fill_blit_assertions (
  input wire logic        hclk,      // Clock
  input wire logic        hresetn,   // Reset, active low
  input wire logic [31:0] haddr,     // Bus address
  input wire logic [1:0]  htrans,    // Transfer type
  input wire logic        hwrite,    // Direction
  input wire logic [31:0] hwdata,    // Write data
  input wire logic        hreadyout, // Slave ready
  input wire logic        hresp,     // Response
  input wire logic        mem_req,   // Memory request
  input wire logic        mem_we,    // Memory write
  input wire logic [23:0] mem_addr,  // Memory address
  input wire logic        mem_ack,   // Memory completion
  input wire logic        busy       // Blit running
);
  logic ctl_wr_reg;  // Control write address phase seen
  wire logic start_seen = ctl_wr_reg & hwdata[7];  // Start data phase
  // Track control writes so the start can be tied to busy
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) ctl_wr_reg <= 1'b0;
    else ctl_wr_reg <= htrans == 2'h2 && hwrite && haddr == 32'h400;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_waiting;
    mem_req && !mem_ack;
  endsequence
  a_ready_high: assert property (hresetn && $past(hresetn) |-> hreadyout) else $error("ready low");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_req_hold: assert property (s_waiting |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  a_addr_even: assert property (mem_req |-> !mem_addr[0]) else $error("odd memory address");
  a_write_release: assert property (mem_req && mem_we && mem_ack |=> !mem_req)
    else $error("request kept after write ack");
  a_idle_quiet: assert property (!busy |-> !mem_req) else $error("request while idle");
  a_start_cause: assert property ($rose(busy) |-> $past(start_seen) || $past(start_seen, 2))
    else $error("busy without start");
  a_busy_fetch: assert property ($rose(busy) |-> ##[0:8] mem_req)
    else $error("no pattern fetch after start");
endmodule
bind pattern_fill_blit pattern_fill_blit_assertions chk (.hclk(hclk), .hresetn(hresetn),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .busy(busy));
`default_nettype wire

// ---- sim/pattern_fill_blit_tb_top.sv ----
// Self-checking bench running pattern fills through the register bus
`timescale 1ns/1ps
`default_nettype none
module pattern_fill_blit_tb_top;
  logic             hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic      [31:0] haddr = 32'h0, hwdata = 32'h0;  // Bus address and data
  logic      [1:0]  htrans = 2'h0;                   // Transfer type
  wire logic        hreadyout, hresp, mem_req, mem_we, mem_ack, busy;
  wire logic [31:0] hrdata;
  wire logic [23:0] mem_addr;
  wire logic [1:0]  mem_be;
  wire logic [15:0] mem_wdata, mem_rdata;
  int               n_errors = 0, n_tests = 0, cycles = 0;
  logic      [7:0]  q;                               // Last read byte
  pattern_fill_blit uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy));
  display_mem_model mem (.clk(hclk), .slow(slow), .req(mem_req), .we(mem_we), .addr(mem_addr),
    .be(mem_be), .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata));
  always #5 hclk = ~hclk;
  // Hang guard at 20000 cycles, far above the several hundred cycles needed
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One single word transfer; waits on ready, no assumed latency
  task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d, output logic [7:0] r);
    haddr <= {20'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  function automatic logic [7:0] raster_operation(input logic [3:0] c, input logic [7:0] p, input logic [7:0] d);
    for (int b = 0; b < 8; b++) raster_operation[b] = c[{p[b], d[b]}];
  endfunction
  // Program a 3x2 fill at 8 bpp from pattern row 1 column 6, then judge memory
  task automatic blit(input logic [7:0] op, code, dst, tc, input string nm);
    logic [9:0] ix [10] = '{10'h101, 10'h102, 10'h103, 10'h104, 10'h108, 10'h10C, 10'h110,
                            10'h112, 10'h114, 10'h100};
    logic [7:0] dv [10];
    logic [7:0] p;
    dv = '{8'h00, code, op, 8'h4E, dst, 8'h08, 8'h02, 8'h01, tc, 8'h80};
    for (int k = 0; k < 10; k++) xfer(1'b1, ix[k], dv[k], q);
    xfer(1'b0, 10'h110, 8'h00, q);
    check("width", q, 8'h02);
    xfer(1'b0, 10'h100, 8'h00, q);
    check("start bit", q, 8'h80);
    for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge hclk);
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 3; c++) begin
        p = mem.m[64 + ((1 + r) % 8) * 8 + (6 + c) % 8];
        if (op == 8'h07) check("pixel", mem.m[dst + r * 16 + c], p == tc ? 8'hEE : p);
        else check("pixel", mem.m[dst + r * 16 + c], raster_operation(code[3:0], p, 8'hEE));
      end
    $display("test %s done", nm);
  endtask
  task automatic test_regs();
    xfer(1'b0, 10'h102, 8'h00, q);
    check("code reset", q, 8'h00);
    xfer(1'b1, 10'h107, 8'hFF, q);
    xfer(1'b0, 10'h107, 8'h00, q);
    check("hole", q, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_copy();
    blit(8'h06, 8'h0C, 8'h80, 8'h00, "copy");
  endtask
  task automatic test_xor();
    slow <= 1'b1;
    blit(8'h06, 8'h06, 8'hA0, 8'h00, "xor");
  endtask
  task automatic test_trans();
    slow <= 1'b0;
    blit(8'h07, 8'h00, 8'hC0, 8'h05, "transparent");
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem.m[i] = i / 64 == 1 ? 8'(i * 3) : 8'hEE;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_copy();
    test_xor();
    test_trans();
    end_sim();
  end
endmodule
`default_nettype wire
